/* File: common/apc_map.svh */
// Register offsets, field positions and timing counts for auto powerdown
`ifndef APC_MAP_SVH
`define APC_MAP_SVH
`define APC_OFF_STATUS_A 3'h0
`define APC_OFF_STATUS_B 3'h1
`define APC_OFF_DIG_OUT 3'h2
`define APC_OFF_RATE_MAIN 3'h4
`define APC_OFF_FIFO_DATA 3'h5
`define APC_OFF_DIG_IN_CCR 3'h7
`define APC_ADDR_DIRECT 4'h8
`define APC_ADDR_AUTOEN 4'h9
`define APC_ADDR_PPCFG 4'hA
`define APC_ADDR_STATUS 4'hB
`define APC_ADDR_PINS 4'hC
`define APC_ADDR_EVENTS 4'hD
`define APC_EN_FDC 0
`define APC_EN_PP 3
`define APC_EN_UART_A 4
`define APC_EN_UART_B 5
`define APC_DOR_RESET_N 2
`define APC_DOR_MOTOR_LO 4
`define APC_DSR_SOFT_RESET 7
`define APC_MSR_IDLE 8'h80
`define APC_TIMER_MS 10
`define APC_CLK_KHZ 20000
`define APC_TIMER_CYCLES (`APC_TIMER_MS * `APC_CLK_KHZ)
`endif

/* File: common/apc_pkg.sv */
// Types for the auto powerdown controller
package apc_pkg;
  typedef enum logic [1:0] {APC_FDC_AWAKE, APC_FDC_WAIT, APC_FDC_DOWN} apc_fdc_e;
  typedef enum logic [1:0] {
    APC_PP_SPP, APC_PP_BIDIR, APC_PP_EPP, APC_PP_ECP
  } apc_ppmode_e;
  // Floppy drive output pin group
  typedef struct packed {
    logic motor_enable_0_out;
    logic drive_select_0_out;
    logic write_data_out;
    logic write_gate_out;
    logic step_direction_out;
    logic step_pulse_out;
    logic head_select_out;
    logic [1:0] density_select_out;
  } apc_fdd_out_s;
  // Floppy drive input pin group
  typedef struct packed {
    logic read_data_in;
    logic write_protect_in;
    logic track_zero_in;
    logic index_pulse_in;
    logic disk_change_in;
  } apc_fdd_in_s;
  // Status from one serial port
  typedef struct packed {
    logic tx_hold_empty;
    logic tx_shift_empty;
    logic rx_fifo_empty;
    logic rx_wait_start;
    logic tx_hold_write;
    logic serial_receive_input;
    logic ring_in;
  } apc_uart_s;
endpackage : apc_pkg

/* File: core/apc_ctrl.sv */
// Auto powerdown controller for floppy, serial and parallel units
`timescale 1ns/1ns
`default_nettype none
`include "apc_map.svh"

module apc_ctrl #(
  parameter int TIMER_CYCLES = `APC_TIMER_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [7:0] avs_writedata_i,
  output logic [7:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Floppy core status and pins
  input wire logic [7:0] fdc_main_status_i,
  input wire logic fdc_int_i,
  input wire logic fdc_head_unloaded_i,
  input wire apc_pkg::apc_fdd_out_s fdd_core_i,
  output apc_pkg::apc_fdd_out_s fdd_pin_o,
  output apc_pkg::apc_fdd_out_s fdd_pin_oe_o,
  input wire apc_pkg::apc_fdd_in_s fdd_pin_i,
  output apc_pkg::apc_fdd_in_s fdd_core_o,
  output logic fdc_powerdown_o,
  // Serial ports
  input wire apc_pkg::apc_uart_s uart_a_i,
  input wire apc_pkg::apc_uart_s uart_b_i,
  output logic [1:0] tx_powerdown_o,
  output logic [1:0] rx_powerdown_o,
  output logic [1:0] ring_int_o,
  // Parallel port
  input wire apc_pkg::apc_ppmode_e ecr_mode_i,
  output logic epp_powerdown_o,
  output logic ecp_powerdown_o
);
  import apc_pkg::*;

  // Register and pin state
  logic [7:0] direct_power_control_reg, next_direct;
  logic [7:0] auto_power_enable_reg, next_autoen;
  logic [7:0] pp_cfg, next_pp_cfg;
  logic [7:0] floppy_digital_output, next_dor;
  logic [7:0] readdata, next_readdata;
  logic ack, next_ack, waitreq_q, fdc_pd_q;
  apc_fdc_e fdc_state, next_fdc_state;
  logic [$clog2(TIMER_CYCLES+1)-1:0] timer, next_timer;
  logic [1:0] rxd_s1, rxd_s2, rxd_s3, ri_s1, ri_s2;
  logic [1:0] tx_pd, next_tx_pd, rx_pd, next_rx_pd;
  logic epp_pd, next_epp_pd, ecp_pd, next_ecp_pd;
  apc_fdd_out_s pin_q, next_pin, oe_q, next_oe;
  apc_fdd_in_s in_s1, in_s2, next_in;
  logic [7:0] wake_count, next_wake_count;

  logic rd, wr, fdc_wake, fdc_ready;
  logic fdc_enabled, pp_enabled;

  function automatic logic wakes_on_write(input logic [2:0] off,
                                          input logic [7:0] d);
    if (off == `APC_OFF_DIG_OUT)
      return (d[`APC_DOR_MOTOR_LO+:4] != 4'h0) || !d[`APC_DOR_RESET_N];
    if (off == `APC_OFF_RATE_MAIN)
      return d[`APC_DSR_SOFT_RESET];
    return off == `APC_OFF_FIFO_DATA;
  endfunction : wakes_on_write

  // One access per request; answer in the following cycle
  assign rd = avs_read_i && !ack;
  assign wr = avs_write_i && !ack;

  // Floppy wake decode; other offsets never wake
  always_comb begin
    fdc_wake = 1'b0;
    if (!avs_address_i[3]) begin
      if (wr)
        fdc_wake = wakes_on_write(avs_address_i[2:0], avs_writedata_i);
      if (rd)
        fdc_wake = (avs_address_i[2:0] == `APC_OFF_RATE_MAIN) ||
                   (avs_address_i[2:0] == `APC_OFF_FIFO_DATA);
    end
  end

  assign fdc_ready = (floppy_digital_output[`APC_DOR_MOTOR_LO+:4] == 4'h0) &&
                     (fdc_main_status_i == `APC_MSR_IDLE) && !fdc_int_i &&
                     fdc_head_unloaded_i;
  assign fdc_enabled = auto_power_enable_reg[`APC_EN_FDC];
  assign pp_enabled = auto_power_enable_reg[`APC_EN_PP];

  // Register file next values
  always_comb begin
    next_direct = direct_power_control_reg;
    next_autoen = auto_power_enable_reg;
    next_pp_cfg = pp_cfg;
    next_dor = floppy_digital_output;
    next_readdata = readdata;
    next_ack = (avs_read_i || avs_write_i) && !ack;
    next_wake_count = wake_count;
    if (fdc_wake && fdc_state == APC_FDC_DOWN)
      next_wake_count = wake_count + 8'h01;
    if (wr) begin
      unique case (avs_address_i)
        {1'b0, `APC_OFF_DIG_OUT}: next_dor = avs_writedata_i;
        `APC_ADDR_DIRECT: next_direct = avs_writedata_i;
        `APC_ADDR_AUTOEN: next_autoen = avs_writedata_i;
        `APC_ADDR_PPCFG: next_pp_cfg = avs_writedata_i;
        default: ;
      endcase
    end
    if (rd) begin
      unique case (avs_address_i)
        {1'b0, `APC_OFF_DIG_OUT}: next_readdata = floppy_digital_output;
        {1'b0, `APC_OFF_RATE_MAIN}: next_readdata = fdc_main_status_i;
        `APC_ADDR_DIRECT: next_readdata = direct_power_control_reg;
        `APC_ADDR_AUTOEN: next_readdata = auto_power_enable_reg;
        `APC_ADDR_PPCFG: next_readdata = pp_cfg;
        `APC_ADDR_STATUS: next_readdata = {1'b0, epp_pd, ecp_pd,
          fdc_state == APC_FDC_DOWN, rx_pd, tx_pd};
        `APC_ADDR_PINS: next_readdata = {3'h0, in_s2};
        `APC_ADDR_EVENTS: next_readdata = wake_count;
        default: next_readdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      direct_power_control_reg <= 8'h00;
      auto_power_enable_reg <= 8'h00;
      pp_cfg <= 8'h00;
      floppy_digital_output <= 8'h00;
      readdata <= 8'h00;
      ack <= 1'b0;
      waitreq_q <= 1'b1;
      wake_count <= 8'h00;
    end else begin
      direct_power_control_reg <= next_direct;
      auto_power_enable_reg <= next_autoen;
      pp_cfg <= next_pp_cfg;
      floppy_digital_output <= next_dor;
      readdata <= next_readdata;
      ack <= next_ack;
      waitreq_q <= !next_ack;
      wake_count <= next_wake_count;
    end
  end

  // Floppy powerdown sequencer
  always_comb begin
    next_fdc_state = fdc_state;
    next_timer = timer;
    unique case (fdc_state)
      APC_FDC_AWAKE: begin
        if (fdc_enabled) begin
          next_fdc_state = APC_FDC_WAIT;
          next_timer = '0;
        end
      end
      APC_FDC_WAIT: begin
        if (timer < TIMER_CYCLES[$bits(timer)-1:0])
          next_timer = timer + 1'b1;
        if (fdc_wake)
          next_timer = '0;
        else if (timer >= TIMER_CYCLES[$bits(timer)-1:0] && fdc_ready)
          next_fdc_state = APC_FDC_DOWN;
      end
      APC_FDC_DOWN: begin
        if (fdc_wake || !fdc_ready) begin
          next_fdc_state = APC_FDC_WAIT;
          next_timer = '0;
        end
      end
    endcase
    if (!fdc_enabled) begin
      next_fdc_state = APC_FDC_AWAKE;
      next_timer = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fdc_state <= APC_FDC_AWAKE;
      timer <= '0;
      fdc_pd_q <= 1'b0;
    end else begin
      fdc_state <= next_fdc_state;
      timer <= next_timer;
      fdc_pd_q <= (next_fdc_state == APC_FDC_DOWN);
    end
  end

  // Floppy pin gating; host bus pins untouched by this block
  always_comb begin
    logic sleep;
    sleep = (fdc_state == APC_FDC_DOWN) || direct_power_control_reg[0];
    next_pin = fdd_core_i;
    next_oe = '1;
    next_oe.motor_enable_0_out = !sleep;
    next_oe.drive_select_0_out = !sleep;
    next_oe.write_data_out = !sleep;
    next_oe.write_gate_out = !sleep;
    next_in = in_s1;
  end

  // Serial and parallel powerdown
  always_comb begin
    apc_uart_s u;
    u = uart_a_i;
    next_tx_pd = tx_pd;
    next_rx_pd = rx_pd;
    for (int i = 0; i < 2; i++) begin
      u = (i == 0) ? uart_a_i : uart_b_i;
      if (!auto_power_enable_reg[`APC_EN_UART_A + i]) begin
        next_tx_pd[i] = 1'b0;
        next_rx_pd[i] = 1'b0;
      end else begin
        if (u.tx_hold_write)
          next_tx_pd[i] = 1'b0;
        else if (u.tx_hold_empty && u.tx_shift_empty)
          next_tx_pd[i] = 1'b1;
        if (rxd_s2[i] != rxd_s3[i])
          next_rx_pd[i] = 1'b0;
        else if (u.rx_fifo_empty && u.rx_wait_start)
          next_rx_pd[i] = 1'b1;
      end
      if (direct_power_control_reg[`APC_EN_UART_A + i]) begin
        next_tx_pd[i] = 1'b1;
        next_rx_pd[i] = 1'b1;
      end
    end
    // Recomputed from live mode every cycle
    next_epp_pd = pp_enabled && (!pp_cfg[0] ||
      (pp_cfg[1] && ecr_mode_i != APC_PP_EPP));
    next_ecp_pd = pp_enabled && (!pp_cfg[1] ||
      ecr_mode_i != APC_PP_ECP);
    if (direct_power_control_reg[`APC_EN_PP]) begin
      next_epp_pd = 1'b1;
      next_ecp_pd = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_pd <= 2'h0;
      rx_pd <= 2'h0;
      epp_pd <= 1'b0;
      ecp_pd <= 1'b0;
      pin_q <= '0;
      oe_q <= '0;
      in_s1 <= '0;
      in_s2 <= '0;
      rxd_s1 <= 2'h3;
      rxd_s2 <= 2'h3;
      rxd_s3 <= 2'h3;
      ri_s1 <= 2'h0;
      ri_s2 <= 2'h0;
    end else begin
      tx_pd <= next_tx_pd;
      rx_pd <= next_rx_pd;
      epp_pd <= next_epp_pd;
      ecp_pd <= next_ecp_pd;
      pin_q <= next_pin;
      oe_q <= next_oe;
      in_s1 <= fdd_pin_i;
      in_s2 <= next_in;
      rxd_s1 <= {uart_b_i.serial_receive_input,
                 uart_a_i.serial_receive_input};
      rxd_s2 <= rxd_s1;
      rxd_s3 <= rxd_s2;
      ri_s1 <= {uart_b_i.ring_in, uart_a_i.ring_in};
      ri_s2 <= ri_s1;
    end
  end

  assign avs_readdata_o = readdata;
  assign avs_waitrequest_o = waitreq_q;
  assign fdd_pin_o = pin_q;
  assign fdd_pin_oe_o = oe_q;
  assign fdd_core_o = in_s2;
  assign fdc_powerdown_o = fdc_pd_q;
  assign tx_powerdown_o = tx_pd;
  assign rx_powerdown_o = rx_pd;
  assign ring_int_o = ri_s2;
  assign epp_powerdown_o = epp_pd;
  assign ecp_powerdown_o = ecp_pd;

  // Checks
  fdc_disable_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !fdc_enabled |=> fdc_state == APC_FDC_AWAKE)
    else $error("floppy not awake after disable");
  fdc_early_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (fdc_state == APC_FDC_WAIT && timer < TIMER_CYCLES[$bits(timer)-1:0])
    |=> fdc_state != APC_FDC_DOWN)
    else $error("floppy slept before timer");
  fdc_wake_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (fdc_state == APC_FDC_DOWN && fdc_wake) |=>
    fdc_state != APC_FDC_DOWN && timer == '0)
    else $error("floppy failed to wake");
  fdc_pins_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (fdc_state == APC_FDC_DOWN) |=> !oe_q.write_gate_out &&
    !oe_q.motor_enable_0_out && oe_q.step_pulse_out)
    else $error("floppy pins not gated");
  fdc_nowake_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (rd && avs_address_i == 4'h0) |-> !fdc_wake)
    else $error("status read woke floppy");
  tx_wake_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (uart_a_i.tx_hold_write && !direct_power_control_reg[4])
    |=> !tx_pd[0])
    else $error("transmitter stayed down");
  uart_gate_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (!auto_power_enable_reg[5] && !direct_power_control_reg[5])
    |=> !rx_pd[1] && !tx_pd[1])
    else $error("serial down while disabled");
  ecp_mode_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (pp_enabled && ecr_mode_i != APC_PP_ECP) |=> ecp_pd)
    else $error("ecp not powered down");
  bus_ack_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (avs_read_i && avs_waitrequest_o) |=> !avs_waitrequest_o)
    else $error("bus answer late");
endmodule : apc_ctrl
`default_nettype wire

/* File: dv/apc_fdd_model.sv */
// Floppy drive model facing the controller's drive pins
`timescale 1ns/1ns
`default_nettype none
module apc_fdd_model (
  // Clock
  input wire logic clk_i,
  // Controller side
  input wire apc_pkg::apc_fdd_out_s pin_i,
  input wire apc_pkg::apc_fdd_out_s oe_i,
  input wire logic [3:0] stat_i,
  output apc_pkg::apc_fdd_out_s line_o,
  output apc_pkg::apc_fdd_in_s drv_o
);
  import apc_pkg::*;
  apc_fdd_out_s last = '0;
  logic rdat = 1'b0;
  // Released lines drift away from the last driven level
  always_comb line_o = (pin_i & oe_i) | (~last & ~oe_i);
  always_ff @(posedge clk_i) begin
    last <= (pin_i & oe_i) | (last & ~oe_i);
    rdat <= ~rdat;
  end
  // Read data toggles every cycle, status lines from the bench
  assign drv_o = {rdat, stat_i};
endmodule : apc_fdd_model
`default_nettype wire

/* File: dv/test_auto_powerdown_control.sv */
// Self-checking bench for the auto powerdown controller
`timescale 1ns/1ns
`default_nettype none
module test_auto_powerdown_control;
  import apc_pkg::*;
  localparam int TC = 20;
  logic clk_i, reset_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [3:0] avs_address_i, stat;
  logic [7:0] avs_writedata_i, avs_readdata_o, fdc_main_status_i, rd;
  logic fdc_int_i, fdc_head_unloaded_i, fdc_powerdown_o, seen;
  logic epp_powerdown_o, ecp_powerdown_o;
  apc_fdd_out_s fdd_core_i, fdd_pin_o, fdd_pin_oe_o, line;
  apc_fdd_in_s fdd_pin_i, fdd_core_o;
  apc_uart_s uart_a_i, uart_b_i;
  apc_ppmode_e ecr_mode_i;
  logic [1:0] tx_powerdown_o, rx_powerdown_o, ring_int_o, cfg;
  // {write, offset, data}
  logic [12:0] stay [7] = '{13'h0000, 13'h0100, 13'h0200, 13'h1204,
    13'h1400, 13'h0700, 13'h1700};
  logic [12:0] wake [5] = '{13'h0400, 13'h0500, 13'h1555, 13'h1480,
    13'h1214};
  int seed, err_total, n_checks, m;

  apc_ctrl #(.TIMER_CYCLES(TC)) i_dut (.*);
  apc_fdd_model i_drive (.clk_i(clk_i), .pin_i(fdd_pin_o),
    .oe_i(fdd_pin_oe_o), .stat_i(stat), .line_o(line), .drv_o(fdd_pin_i));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  function automatic logic exp_epp(logic en, logic [1:0] c, apc_ppmode_e md);
    return en & (!c[0] | (c[1] & (md != APC_PP_EPP)));
  endfunction : exp_epp

  function automatic logic exp_ecp(logic en, logic [1:0] c, apc_ppmode_e md);
    return en & (!c[1] | (md != APC_PP_ECP));
  endfunction : exp_ecp

  task chk(input logic [8:0] g, input logic [8:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= ~w;
    avs_writedata_i <= d;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    rd = avs_readdata_o;
    if (n == 50) err_total++;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task rdc(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(9'(rd), 9'(e));
  endtask : rdc

  task sleep_chk;
    cyc(TC - 10);
    chk(9'(fdc_powerdown_o), 9'h000);
    cyc(22);
    chk(9'(fdc_powerdown_o), 9'h001);
  endtask : sleep_chk

  task scan(input int w);
    seen = 1'b0;
    repeat (6) begin
      @(posedge clk_i);
      if ((w == 0 ? tx_powerdown_o[0] : rx_powerdown_o[1]) === 1'b0)
        seen = 1'b1;
    end
  endtask : scan

  task complete_run;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  initial begin
    #1000000;
    err_total++;
    complete_run();
  end

  initial begin
    seed = 18;
    err_total = 0;
    n_checks = 0;
    reset_i = 1'b1;
    {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
    fdc_main_status_i = 8'h80;
    fdc_int_i = 1'b0;
    fdc_head_unloaded_i = 1'b1;
    fdd_core_i = {1'b1, 8'($random(seed))};
    stat = 4'($random(seed));
    uart_a_i = 7'h78;
    uart_b_i = 7'h78;
    ecr_mode_i = APC_PP_SPP;
    cyc(6);
    reset_i <= 1'b0;
    rdc(4'h9, 8'h00);
    rdc(4'hB, 8'h00);
    rdc(4'h0, 8'h00);
    bus(1'b1, 4'hF, 8'hFF);
    rdc(4'hE, 8'h00);
    bus(1'b1, 4'h9, 8'h01);
    sleep_chk();
    cyc(2);
    chk(fdd_pin_oe_o, 9'h01F);
    chk(line & 9'h01F, fdd_core_i & 9'h01F);
    chk(9'(fdd_core_o & 5'h0F), 9'(fdd_pin_i & 5'h0F));
    for (m = 0; m < 7; m++) begin
      bus(stay[m][12], stay[m][11:8], stay[m][7:0]);
      chk(9'(fdc_powerdown_o), 9'h001);
    end
    for (m = 0; m < 5; m++) begin
      bus(wake[m][12], wake[m][11:8], wake[m][7:0]);
      chk(9'(fdc_powerdown_o), 9'h000);
      if (m == 4) bus(1'b1, 4'h2, 8'h04);
      sleep_chk();
    end
    for (m = 0; m < 3; m++) begin
      fdc_int_i <= (m == 0);
      fdc_main_status_i <= (m == 1) ? 8'h90 : 8'h80;
      fdc_head_unloaded_i <= (m != 2);
      bus(1'b0, 4'h4, 8'h00);
      cyc(TC + 12);
      chk(9'(fdc_powerdown_o), 9'h000);
    end
    fdc_int_i <= 1'b0;
    fdc_main_status_i <= 8'h80;
    fdc_head_unloaded_i <= 1'b1;
    bus(1'b0, 4'h4, 8'h00);
    sleep_chk();
    bus(1'b1, 4'h9, 8'h00);
    cyc(2);
    chk(9'(fdc_powerdown_o), 9'h000);
    cyc(TC + 12);
    chk(9'({fdc_powerdown_o, tx_powerdown_o, rx_powerdown_o}), 9'h000);
    bus(1'b1, 4'h9, 8'h30);
    rdc(4'h9, 8'h30);
    cyc(3);
    chk(9'({tx_powerdown_o, rx_powerdown_o}), 9'h00F);
    uart_a_i <= 7'h38;
    uart_b_i <= 7'h70;
    cyc(4);
    // With auto powerdown enabled, only a buffer write or a receive edge brings a port back up
    chk(9'({tx_powerdown_o, rx_powerdown_o}), 9'h00F);
    uart_a_i <= 7'h78;
    uart_b_i <= 7'h78;
    cyc(4);
    uart_a_i <= 7'h7C;
    @(posedge clk_i);
    uart_a_i <= 7'h78;
    scan(0);
    chk(9'(seen), 9'h001);
    uart_b_i <= 7'h7A;
    scan(1);
    chk(9'(seen), 9'h001);
    uart_a_i <= 7'h79;
    cyc(4);
    chk(9'(ring_int_o), 9'h001);
    for (m = 0; m < 24; m++) begin
      cfg = 2'($random(seed));
      bus(1'b1, 4'h9, {4'h3, m[0], 3'h0});
      bus(1'b1, 4'hA, {6'h00, cfg});
      ecr_mode_i <= apc_ppmode_e'($random(seed));
      cyc(3);
      chk(9'({epp_powerdown_o, ecp_powerdown_o}), 9'({exp_epp(m[0], cfg,
        ecr_mode_i), exp_ecp(m[0], cfg, ecr_mode_i)}));
    end
    bus(1'b1, 4'h8, 8'h39);
    cyc(3);
    chk(9'({tx_powerdown_o, rx_powerdown_o, epp_powerdown_o,
      ecp_powerdown_o}), 9'h03F);
    chk(fdd_pin_oe_o, 9'h01F);
    rdc(4'hB, 8'h6F);
    complete_run();
  end
endmodule : test_auto_powerdown_control
`default_nettype wire
